// >>> scr_charger_regs.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - word read is start, address+write, command, repeated start, address+read.
// - direction bit low writes, high reads; acknowledge pulls data low on clock nine.
// - read returns low byte then high byte; master acks low, nacks high, stops.
// - slave only, answers only to address 0001001, never starts a transfer.
// - six commands, each reachable by word write or word read.
// - two read-only identity commands return fixed 16-bit codes.
// - charge-current register read/write, 7-bit setting, resets to zero.
// - charge-voltage register read/write, 11-bit setting, resets to zero.
// - input-current register read/write, 6-bit setting, resets to 0x1000.
// - options register at 0x12, resets to 0x7904, writable any time.
// - bus works only with supply above lockout and adapter detect valid.
// - options bit 15 picks adapter-good rise deglitch, 150 ms or 1.3 s.
// - long deglitch only after adapter switch went on then off once.
// - enabled watchdog suspends charging without a current or voltage write.
// - a current or voltage write resumes charging after watchdog expiry.
// - in learn, depletion swaps battery switch off and adapter switch on.
// - options bits 12:11 select the depletion threshold, passed out as is.
// - learn bit swaps to battery, then clears itself when learn finishes.
module scr_charger_regs import scr_pkg::*; #(
	parameter int MS_CLKS = MS_CYCLES,
	parameter logic [15:0] MAKER_CODE = 16'h5A5A, // arbitrary value
	parameter logic [15:0] PART_CODE = 16'h00A5 // arbitrary value
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// two-wire bus pins
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe_b,
	// analog status inputs
	input wire logic supplyOk,
	input wire logic adapterDetectOk,
	input wire logic adapterPresent,
	input wire logic batteryDepleted,
	// settings to the charger core
	output logic [15:0] chargerOptions,
	output logic [15:0] chargeCurrentLimit,
	output logic [15:0] chargeVoltageLimit,
	output logic [15:0] inputCurrentLimit,
	// power path and charge control
	output logic chargeEnable,
	output logic adapterGoodFlag,
	output logic adapterSwitch,
	output logic batterySwitch
);
	scr_state_t st;
	scr_state_t next_st;
	logic [1:0] rstPipe;
	logic rstSync_b;
	logic msTick;

	if (MS_CLKS < 1 || MS_CLKS > 65535) begin : g_chk
		$error("scr_charger_regs: MS_CLKS out of range");
	end

	//////////////////////////////////////////////////////////////////////////
	// reset release and millisecond tick

	// reset asserted at once, released after two clocks
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstPipe <= 2'b00;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstSync_b = rstPipe[1];

	scr_tick_div #(.CYCLES(MS_CLKS)) uTick (
		.mclk(mclk),
		.rst_b(rstSync_b),
		.tick(msTick)
	);

	//////////////////////////////////////////////////////////////////////////
	// register read mux

	// unknown commands read as zero
	function automatic logic [15:0] readWord(input scr_state_t s);
		case (s.cmd)
			CMD_OPT: readWord = s.options;
			CMD_CUR: readWord = s.charge_current_limit;
			CMD_VOLT: readWord = s.charge_voltage_limit;
			CMD_IN: readWord = s.input_current_limit;
			CMD_MAKER: readWord = MAKER_CODE;
			CMD_PART: readWord = PART_CODE;
			default: readWord = 16'h0000;
		endcase
	endfunction : readWord

	// watchdog period for a selection
	function automatic logic [17:0] wdogLimit(input logic [1:0] sel);
		case (sel)
			WDOG_SHORT: wdogLimit = WDOG_SHORT_MS;
			WDOG_MID: wdogLimit = WDOG_MID_MS;
			default: wdogLimit = WDOG_LONG_MS;
		endcase
	endfunction : wdogLimit

	//////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		logic sclNow;
		logic sdaNow;
		logic busOn;
		logic sclRise;
		logic sclFall;
		logic startCond;
		logic stopCond;
		logic wrCur;
		logic wrVolt;
		logic wrOpt;
		logic [15:0] word;
		logic [1:0] wdSel;
		logic [10:0] glitchLim;
		logic learning;
		logic [15:0] rdData;
		next_st = st;
		wrCur = 1'b0;
		wrVolt = 1'b0;
		wrOpt = 1'b0;
		word = {st.shift, st.dataLo};
		// locals start from a known value
		sclNow = 1'b0;
		sdaNow = 1'b0;
		busOn = 1'b0;
		sclRise = 1'b0;
		sclFall = 1'b0;
		startCond = 1'b0;
		stopCond = 1'b0;
		wdSel = WDOG_OFF;
		glitchLim = GLITCH_SHORT;
		learning = 1'b0;
		// read word fetched once; bit 7 leads the low byte
		rdData = readWord(st);
		// two-flop synchronisers for every pin
		next_st.syncA = {batteryDepleted, adapterPresent, adapterDetectOk, supplyOk, sdaIn, scl};
		next_st.syncB = st.syncA;
		sclNow = st.syncB[PIN_SCL];
		sdaNow = st.syncB[PIN_SDA];
		next_st.sclPrev = sclNow;
		next_st.sdaPrev = sdaNow;
		busOn = st.syncB[PIN_VCC] & st.syncB[PIN_DET];
		// edges from the synced copy against one more flop
		sclRise = sclNow & ~st.sclPrev;
		sclFall = ~sclNow & st.sclPrev;
		startCond = sclNow & st.sclPrev & st.sdaPrev & ~sdaNow;
		stopCond = sclNow & st.sclPrev & ~st.sdaPrev & sdaNow;

		// bus engine: slave only, never drives the clock
		if (!busOn || stopCond) begin
			next_st.bus = BUS_IDLE;
			next_st.sdaOe_b = 1'b1;
		end else if (startCond) begin
			next_st.bus = BUS_RECV;
			next_st.phase = PH_ADDR;
			next_st.bitCnt = 4'h0;
			next_st.sdaOe_b = 1'b1;
		end else begin
			case (st.bus)
				BUS_RECV: begin
					// shift on each rise, act on the eighth fall
					if (sclRise) begin
						next_st.shift = {st.shift[6:0], sdaNow};
						next_st.bitCnt = st.bitCnt + 4'h1;
					end else if (sclFall && st.bitCnt == 4'h8) begin
						next_st.bitCnt = 4'h0;
						next_st.bus = BUS_ACK;
						next_st.sdaOe_b = 1'b0;
						case (st.phase)
							PH_ADDR: begin
								if (st.shift[7:1] == SLAVE_ADDR) begin
									next_st.isRead = st.shift[0];
								end else begin
									next_st.bus = BUS_WAIT;
									next_st.sdaOe_b = 1'b1;
								end
							end
							PH_CMD: next_st.cmd = st.shift;
							PH_LO: next_st.dataLo = st.shift;
							default: begin
								// complete word write, low byte first
								case (st.cmd)
									CMD_OPT: begin
										next_st.options = word;
										wrOpt = 1'b1;
									end
									CMD_CUR: begin
										next_st.charge_current_limit = word & CUR_MASK;
										wrCur = 1'b1;
									end
									CMD_VOLT: begin
										next_st.charge_voltage_limit = word & VOLT_MASK;
										wrVolt = 1'b1;
									end
									CMD_IN: next_st.input_current_limit = word & IN_MASK;
									default: ;
								endcase
							end
						endcase
					end
				end
				BUS_ACK: begin
					if (sclFall) begin
						next_st.sdaOe_b = 1'b1;
						next_st.bus = BUS_RECV;
						case (st.phase)
							PH_ADDR: begin
								if (st.isRead) begin
									next_st.txWord = rdData;
									next_st.sdaOe_b = rdData[7];
									next_st.bus = BUS_SEND;
								end
								next_st.phase = PH_CMD;
							end
							PH_CMD: next_st.phase = PH_LO;
							PH_LO: next_st.phase = PH_HI;
							default: next_st.bus = BUS_WAIT;
						endcase
					end
				end
				BUS_SEND: begin
					// next bit goes out just after the clock falls
					if (sclFall) begin
						if (st.bitCnt == 4'h7) begin
							next_st.bitCnt = 4'h0;
							next_st.sdaOe_b = 1'b1;
							next_st.bus = BUS_MACK;
						end else begin
							next_st.bitCnt = st.bitCnt + 4'h1;
							next_st.txWord = {st.txWord[15:8], st.txWord[6:0], 1'b0};
							next_st.sdaOe_b = st.txWord[6];
						end
					end
				end
				BUS_MACK: begin
					// a released line on the ninth rise is a refusal
					if (sclRise && sdaNow) begin
						next_st.bus = BUS_WAIT;
					end else if (sclFall) begin
						// master acked: high byte follows
						next_st.txWord = {8'h00, st.txWord[15:8]};
						next_st.sdaOe_b = st.txWord[15];
						next_st.bus = BUS_SEND;
					end
				end
				BUS_WAIT: next_st.sdaOe_b = 1'b1;
				BUS_IDLE: next_st.sdaOe_b = 1'b1;
				default: begin
					next_st.bus = BUS_IDLE;
					next_st.sdaOe_b = 1'b1;
				end
			endcase
		end
		next_st.sdaOut = 1'b0;

		// charge watchdog
		// after expiry the count holds until a current or voltage write
		wdSel = st.options[OPT_WDOG_HI:OPT_WDOG_LO];
		if (wrCur || wrVolt) begin
			next_st.wdogMs = 18'h0_0000;
			next_st.chargeSuspended = 1'b0;
		end else if (wdSel == WDOG_OFF) begin
			next_st.wdogMs = 18'h0_0000;
			next_st.chargeSuspended = 1'b0;
		end else if (msTick && !st.chargeSuspended) begin
			if (st.wdogMs >= wdogLimit(wdSel) - 18'h0_0001) begin
				next_st.wdogMs = 18'h0_0000;
				next_st.chargeSuspended = 1'b1;
			end else begin
				next_st.wdogMs = st.wdogMs + 18'h0_0001;
			end
		end
		next_st.chargeEnable = ~next_st.chargeSuspended;

		// adapter-good rising deglitch
		glitchLim = (st.options[OPT_DEGLITCH] && st.switchCycled) ? GLITCH_LONG : GLITCH_SHORT;
		if (!st.syncB[PIN_ADAPT]) begin
			next_st.glitchMs = 11'h000;
			next_st.adapterGood = 1'b0;
		end else if (!st.adapterGood && msTick) begin
			if (st.glitchMs >= glitchLim - 11'h001) begin
				next_st.adapterGood = 1'b1;
			end else begin
				next_st.glitchMs = st.glitchMs + 11'h001;
			end
		end

		// first on-then-off of the adapter switch arms the long deglitch
		if (st.adapterSwitch) begin
			next_st.switchSeenOn = 1'b1;
		end
		if (st.switchSeenOn && !st.adapterSwitch) begin
			next_st.switchCycled = 1'b1;
		end

		// learn cycle and power path; a host write beats the self-clear
		learning = st.options[OPT_LEARN];
		if (learning && st.syncB[PIN_DEPL] && !wrOpt) begin
			next_st.options[OPT_LEARN] = 1'b0;
		end
		next_st.adapterSwitch = learning ? 1'b0 : st.adapterGood;
		next_st.batterySwitch = learning ? 1'b1 : ~st.adapterGood;
	end

	//////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			st <= '0;
			st.bus <= BUS_IDLE;
			st.sdaOe_b <= 1'b1;
			st.options <= OPT_RST;
			st.charge_current_limit <= CUR_RST;
			st.charge_voltage_limit <= VOLT_RST;
			st.input_current_limit <= IN_RST;
			st.chargeEnable <= 1'b1;
			st.batterySwitch <= 1'b1;
			// bus lines idle high, so no false edge follows reset
			st.syncA[PIN_SCL] <= 1'b1;
			st.syncA[PIN_SDA] <= 1'b1;
			st.syncB[PIN_SCL] <= 1'b1;
			st.syncB[PIN_SDA] <= 1'b1;
			st.sclPrev <= 1'b1;
			st.sdaPrev <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign sdaOut = st.sdaOut;
	assign sdaOe_b = st.sdaOe_b;
	assign chargerOptions = st.options;
	assign chargeCurrentLimit = st.charge_current_limit;
	assign chargeVoltageLimit = st.charge_voltage_limit;
	assign inputCurrentLimit = st.input_current_limit;
	assign chargeEnable = st.chargeEnable;
	assign adapterGoodFlag = st.adapterGood;
	assign adapterSwitch = st.adapterSwitch;
	assign batterySwitch = st.batterySwitch;
endmodule : scr_charger_regs

// >>> scr_pkg.sv
package scr_pkg;
	// bus identity and command codes
	localparam logic [6:0] SLAVE_ADDR = 7'h09;
	localparam logic [7:0] CMD_OPT = 8'h12;
	localparam logic [7:0] CMD_CUR = 8'h14;
	localparam logic [7:0] CMD_VOLT = 8'h15;
	localparam logic [7:0] CMD_IN = 8'h3F;
	localparam logic [7:0] CMD_MAKER = 8'hFE;
	localparam logic [7:0] CMD_PART = 8'hFF;
	// power-on values and implemented setting bits
	localparam logic [15:0] OPT_RST = 16'h7904;
	localparam logic [15:0] CUR_RST = 16'h0000;
	localparam logic [15:0] VOLT_RST = 16'h0000;
	localparam logic [15:0] IN_RST = 16'h1000;
	localparam logic [15:0] CUR_MASK = 16'h1FC0;
	localparam logic [15:0] VOLT_MASK = 16'h7FF0;
	localparam logic [15:0] IN_MASK = 16'h1F80;
	// option field positions
	localparam int OPT_DEGLITCH = 15;
	localparam int OPT_WDOG_HI = 14;
	localparam int OPT_WDOG_LO = 13;
	localparam int OPT_LEARN = 6;
	// watchdog selections
	localparam logic [1:0] WDOG_OFF = 2'h0;
	localparam logic [1:0] WDOG_SHORT = 2'h1;
	localparam logic [1:0] WDOG_MID = 2'h2;
	// timing
	localparam int CLK_HZ = 25_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int DEGLITCH_SHORT_MS = 150;
	localparam int DEGLITCH_LONG_MS = 1300;
	localparam int WDOG_SHORT_S = 44;
	localparam int WDOG_MID_S = 88;
	localparam int WDOG_LONG_S = 175;
	localparam logic [10:0] GLITCH_SHORT = 11'(DEGLITCH_SHORT_MS);
	localparam logic [10:0] GLITCH_LONG = 11'(DEGLITCH_LONG_MS);
	localparam logic [17:0] WDOG_SHORT_MS = 18'(WDOG_SHORT_S * MS_PER_S);
	localparam logic [17:0] WDOG_MID_MS = 18'(WDOG_MID_S * MS_PER_S);
	localparam logic [17:0] WDOG_LONG_MS = 18'(WDOG_LONG_S * MS_PER_S);
	// synchronised pin positions
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_VCC = 2;
	localparam int PIN_DET = 3;
	localparam int PIN_ADAPT = 4;
	localparam int PIN_DEPL = 5;
	localparam int PIN_COUNT = 6;
	// byte position inside a transfer
	localparam logic [1:0] PH_ADDR = 2'h0;
	localparam logic [1:0] PH_CMD = 2'h1;
	localparam logic [1:0] PH_LO = 2'h2;
	localparam logic [1:0] PH_HI = 2'h3;

	typedef enum logic [5:0] {
		BUS_IDLE = 6'b000001,
		BUS_RECV = 6'b000010,
		BUS_ACK = 6'b000100,
		BUS_SEND = 6'b001000,
		BUS_MACK = 6'b010000,
		BUS_WAIT = 6'b100000
	} scr_bus_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} scr_div_t;

	typedef struct packed {
		logic [PIN_COUNT-1:0] syncA;
		logic [PIN_COUNT-1:0] syncB;
		logic sclPrev;
		logic sdaPrev;
		scr_bus_t bus;
		logic [1:0] phase;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic isRead;
		logic [7:0] cmd;
		logic [7:0] dataLo;
		logic [15:0] txWord;
		logic sdaOe_b;
		logic sdaOut;
		logic [15:0] options;
		logic [15:0] charge_current_limit;
		logic [15:0] charge_voltage_limit;
		logic [15:0] input_current_limit;
		logic [17:0] wdogMs;
		logic chargeSuspended;
		logic chargeEnable;
		logic [10:0] glitchMs;
		logic adapterGood;
		logic switchSeenOn;
		logic switchCycled;
		logic adapterSwitch;
		logic batterySwitch;
	} scr_state_t;
endpackage : scr_pkg

// >>> scr_tick_div.sv
`timescale 1ns/100ps
// one-cycle tick every CYCLES clocks
module scr_tick_div import scr_pkg::*; #(
	parameter int CYCLES = MS_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// tick out
	output logic tick
);
	scr_div_t st;
	scr_div_t next_st;

	if (CYCLES < 1 || CYCLES > 65535) begin : g_chk
		$error("scr_tick_div: CYCLES out of range");
	end

	// count down the period, pulse on wrap
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.cnt == 16'h0000) begin
			next_st.cnt = 16'(CYCLES - 1);
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt - 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
endmodule : scr_tick_div

// >>> scr_charger_regs_asserts.sv
`timescale 1ns/100ps
module scr_charger_regs_asserts import scr_pkg::*; #(
	parameter int MS_CLKS = MS_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// bus and status pins
	input wire logic scl,
	input wire logic sdaOe_b,
	input wire logic supplyOk,
	input wire logic adapterPresent,
	// settings and power path
	input wire logic [15:0] chargerOptions,
	input wire logic [15:0] chargeCurrentLimit,
	input wire logic [15:0] chargeVoltageLimit,
	input wire logic chargeEnable,
	input wire logic adapterGoodFlag,
	input wire logic adapterSwitch,
	input wire logic batterySwitch
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// cycles the adapter comparator has stood high
	int presentRun;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			presentRun <= 0;
		end else if (adapterPresent) begin
			presentRun <= presentRun + 1;
		end else begin
			presentRun <= 0;
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	// register fields and bus behaviour
	cur_field_a: assert property ((chargeCurrentLimit & ~CUR_MASK) == 16'h0000)
		else $error("current setting outside its field");
	volt_field_a: assert property ((chargeVoltageLimit & ~VOLT_MASK) == 16'h0000)
		else $error("voltage setting outside its field");
	no_start_a: assert property ($fell(sdaOe_b) |-> !scl)
		else $error("device pulled data while clock high");
	bus_silent_a: assert property (!supplyOk [*8] |-> sdaOe_b)
		else $error("device answered below lockout");
	//////////////////////////////////////////////////////////////////////////////
	// power path, deglitch and watchdog
	learn_swap_a: assert property ($rose(chargerOptions[6]) |-> ##[0:2] (!adapterSwitch && batterySwitch))
		else $error("learn did not move to battery");
	flag_drop_a: assert property (!adapterPresent [*5] |-> !adapterGoodFlag)
		else $error("adapter good stayed without adapter");
	flag_rise_a: assert property ($rose(adapterGoodFlag) |-> presentRun >= DEGLITCH_SHORT_MS * MS_CLKS)
		else $error("adapter good rose without deglitch");
	wdog_fall_a: assert property ($fell(chargeEnable) |-> chargerOptions[14:13] != WDOG_OFF)
		else $error("charge suspended with watchdog off");
	wdog_off_a: assert property (chargerOptions[14:13] == WDOG_OFF |-> ##[0:2] chargeEnable)
		else $error("charge held off with watchdog off");
	// main scenarios reached
	cover property ($fell(chargeEnable));
	cover property ($fell(chargerOptions[6]));
	cover property ($rose(adapterGoodFlag));
endmodule : scr_charger_regs_asserts

bind scr_charger_regs scr_charger_regs_asserts #(.MS_CLKS(MS_CLKS)) u_scr_charger_regs_asserts (
	.mclk(mclk), .rst_b(rst_b), .scl(scl), .sdaOe_b(sdaOe_b), .supplyOk(supplyOk),
	.adapterPresent(adapterPresent), .chargerOptions(chargerOptions),
	.chargeCurrentLimit(chargeCurrentLimit), .chargeVoltageLimit(chargeVoltageLimit),
	.chargeEnable(chargeEnable), .adapterGoodFlag(adapterGoodFlag),
	.adapterSwitch(adapterSwitch), .batterySwitch(batterySwitch)
);

// >>> scr_host_model.sv
`timescale 1ns/100ps
module scr_host_model import scr_pkg::*; (
	// clock
	input wire logic mclk,
	// bus wires
	input wire logic sdaWire,
	output logic scl,
	output logic sdaDrv_b
);
	// both lines released and pulled high between frames
	initial begin
		scl = 1'b1;
		sdaDrv_b = 1'b1;
	end
	// one quarter of a 320 ns bus clock per step
	task automatic drive(input logic c, input logic d);
		scl <= c;
		sdaDrv_b <= d;
		repeat (2) @(posedge mclk);
	endtask : drive
	// data changes only while clock low; sample at the middle of the high phase
	task automatic bitIo(input logic b, output logic s);
		drive(1'b0, b);
		drive(1'b1, b);
		s = sdaWire;
		drive(1'b1, b);
		drive(1'b0, b);
	endtask : bitIo
	// bytes go msb first, ninth clock is the acknowledge
	task automatic sendByte(input logic [7:0] d, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitIo(d[i], s);
		end
		bitIo(1'b1, nack);
	endtask : sendByte
	task automatic recvByte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitIo(1'b1, d[i]);
		end
		bitIo(last, s);
	endtask : recvByte
	// start when idle or repeated start mid frame, then stop
	task automatic busStart();
		drive(scl, 1'b1);
		drive(1'b1, 1'b1);
		drive(1'b1, 1'b0);
		drive(1'b0, 1'b0);
	endtask : busStart
	task automatic busStop();
		drive(1'b0, 1'b0);
		drive(1'b1, 1'b0);
		drive(1'b1, 1'b1);
	endtask : busStop
	// word write: low byte then high byte
	task automatic wrWord(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
		output logic ok);
		logic n0, n1, n2, n3;
		busStart();
		sendByte({a, 1'b0}, n0);
		sendByte(c, n1);
		sendByte(d[7:0], n2);
		sendByte(d[15:8], n3);
		busStop();
		ok = !(n0 | n1 | n2 | n3);
	endtask : wrWord
	// word read: command, repeated start, low byte acked, high byte refused
	task automatic rdWord(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d,
		output logic ok);
		logic n0, n1, n2;
		busStart();
		sendByte({a, 1'b0}, n0);
		sendByte(c, n1);
		busStart();
		sendByte({a, 1'b1}, n2);
		recvByte(1'b0, d[7:0]);
		recvByte(1'b1, d[15:8]);
		busStop();
		ok = !(n0 | n1 | n2);
	endtask : rdWord
endmodule : scr_host_model

// >>> scr_charger_regs_tb.sv
`timescale 1ns/100ps
module scr_charger_regs_tb import scr_pkg::*; ();
	localparam logic [15:0] MAKER = 16'h3C3C; // arbitrary value
	localparam logic [15:0] PART = 16'h00C3; // arbitrary value
	logic mclk, rst_b, scl, sdaDrv_b, sdaOut, sdaOe_b, ok;
	logic supplyOk, adapterDetectOk, adapterPresent, batteryDepleted;
	logic [15:0] chargerOptions, chargeCurrentLimit, chargeVoltageLimit, inputCurrentLimit;
	logic chargeEnable, adapterGoodFlag, adapterSwitch, batterySwitch;
	int miscompares = 0;
	int samples_checked = 0;
	logic [7:0] cmds [6] = '{CMD_OPT, CMD_CUR, CMD_VOLT, CMD_IN, CMD_MAKER, CMD_PART};
	logic [15:0] powerOn [6] = '{OPT_RST, CUR_RST, VOLT_RST, IN_RST, MAKER, PART};
	logic [15:0] allOnes [6] = '{16'hFFFF, CUR_MASK, VOLT_MASK, IN_MASK, MAKER, PART};
	// open-drain data wire with pull-up
	wire logic sdaWire = sdaDrv_b & sdaOe_b;
	//////////////////////////////////////////////////////////////////////////////
	scr_charger_regs #(.MS_CLKS(1), .MAKER_CODE(MAKER), .PART_CODE(PART)) u_scr_charger_regs (
		.mclk(mclk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
		.sdaOe_b(sdaOe_b), .supplyOk(supplyOk), .adapterDetectOk(adapterDetectOk),
		.adapterPresent(adapterPresent), .batteryDepleted(batteryDepleted),
		.chargerOptions(chargerOptions), .chargeCurrentLimit(chargeCurrentLimit),
		.chargeVoltageLimit(chargeVoltageLimit), .inputCurrentLimit(inputCurrentLimit),
		.chargeEnable(chargeEnable), .adapterGoodFlag(adapterGoodFlag),
		.adapterSwitch(adapterSwitch), .batterySwitch(batterySwitch)
	);
	scr_host_model u_scr_host_model (.mclk(mclk), .sdaWire(sdaWire), .scl(scl), .sdaDrv_b(sdaDrv_b));
	// 25 MHz clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
	endtask : hold
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		logic a;
		u_scr_host_model.wrWord(SLAVE_ADDR, c, d, a);
		chk("write ack", 16'(a), 16'h0001);
	endtask : wr
	task automatic rd(input string what, input logic [7:0] c, input logic [15:0] exp);
		logic [15:0] d;
		logic a;
		u_scr_host_model.rdWord(SLAVE_ADDR, c, d, a);
		chk("read ack", 16'(a), 16'h0001);
		chk(what, d, exp);
	endtask : rd
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	// cut a hang short well beyond the expected run length
	initial begin
		repeat (100000) @(posedge mclk);
		miscompares++;
		complete_run();
	end
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		supplyOk = 1'b1;
		adapterDetectOk = 1'b1;
		adapterPresent = 1'b0;
		batteryDepleted = 1'b0;
		hold(2);
		rst_b <= 1'b1;
		hold(12);
		// power-on values, then every field written with ones
		for (int i = 0; i < 6; i++) begin
			rd("power-on value", cmds[i], powerOn[i]);
		end
		for (int i = 0; i < 6; i++) begin
			wr(cmds[i], 16'hFFFF);
			rd("written value", cmds[i], allOnes[i]);
		end
		wr(CMD_OPT, OPT_RST);
		chk("current port", chargeCurrentLimit, CUR_MASK);
		chk("voltage port", chargeVoltageLimit, VOLT_MASK);
		chk("input port", inputCurrentLimit, IN_MASK);
		chk("options port", chargerOptions, OPT_RST);
		chk("data out level", 16'(sdaOut), 16'h0000);
		// refused accesses leave the settings alone
		rd("unknown command", 8'h13, 16'h0000);
		u_scr_host_model.wrWord(7'h0A, CMD_CUR, 16'h0040, ok);
		chk("foreign address ack", 16'(ok), 16'h0000);
		for (int i = 0; i < 2; i++) begin
			supplyOk <= i[0];
			adapterDetectOk <= !i[0];
			hold(8);
			u_scr_host_model.wrWord(SLAVE_ADDR, CMD_CUR, 16'h0040, ok);
			chk("ack while disabled", 16'(ok), 16'h0000);
		end
		supplyOk <= 1'b1;
		adapterDetectOk <= 1'b1;
		hold(8);
		rd("current kept", CMD_CUR, CUR_MASK);
		$display("test access done");
		// first insertion uses the short deglitch even with long selected
		wr(CMD_OPT, 16'hF904);
		adapterPresent <= 1'b1;
		hold(140);
		chk("flag before short", 16'(adapterGoodFlag), 16'h0000);
		hold(30);
		chk("flag after short", 16'(adapterGoodFlag), 16'h0001);
		wr(CMD_OPT, 16'hF944);
		hold(4);
		chk("learn switches", 16'({adapterSwitch, batterySwitch}), 16'h0001);
		batteryDepleted <= 1'b1;
		hold(8);
		chk("learn bit", 16'(chargerOptions[6]), 16'h0000);
		chk("depleted switches", 16'({adapterSwitch, batterySwitch}), 16'h0002);
		batteryDepleted <= 1'b0;
		adapterPresent <= 1'b0;
		hold(8);
		chk("adapter switch off", 16'(adapterSwitch), 16'h0000);
		adapterPresent <= 1'b1;
		hold(1250);
		chk("flag before long", 16'(adapterGoodFlag), 16'h0000);
		hold(100);
		chk("flag after long", 16'(adapterGoodFlag), 16'h0001);
		$display("test power path done");
		// 44 s watchdog at one tick per clock
		wr(CMD_OPT, 16'h3904);
		wr(CMD_CUR, 16'h0040);
		hold(43000);
		chk("charging before expiry", 16'(chargeEnable), 16'h0001);
		hold(1500);
		chk("charging after expiry", 16'(chargeEnable), 16'h0000);
		wr(CMD_VOLT, 16'h0010);
		hold(4);
		chk("charging resumed", 16'(chargeEnable), 16'h0001);
		wr(CMD_OPT, 16'h1904);
		rd("watchdog off", CMD_OPT, 16'h1904);
		$display("test watchdog done");
		complete_run();
	end
endmodule : scr_charger_regs_tb
